/* File: src/sft_pkg.sv */
// Shared constants for the SDLC frame transmitter
package sft_pkg;
  localparam logic [7:0] SFT_FLAG = 8'h7e;
  localparam logic [15:0] SFT_CRC_PRESET = 16'hffff;
  localparam logic [15:0] SFT_CRC_POLY = 16'h8408;
  localparam logic [3:0] SFT_LEN_RESET = 4'h8;
  localparam logic [3:0] SFT_LEN_MIN = 4'h5;
  localparam logic [4:0] SFT_ABORT_ONES = 5'h08;
  localparam int SFT_FIFO_WIDTH = 12;
  localparam int SFT_FIFO_DEPTH = 32;
  typedef enum logic [2:0] {
    SFT_IDLE, SFT_FLAGS, SFT_DATA, SFT_CRC, SFT_CLOSE, SFT_ABORT
  } sft_state_type;
endpackage : sft_pkg

/* File: src/sft_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides
module sft_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // sft_fifo

/* File: src/sft_transmitter.sv */
// SDLC frame transmitter: flags, zero insertion, CRC, abort
// Summary of operation
// - Reset CRC command presets generator to ones
// - Flags start once enabled and CTS active
// - CTS change first, then buffer-empty requests
// - New word length applies to later characters
// - On empty with latch reset: CRC, closing flag, buffer-empty
// - Underrun with latch reset sends CRC, interrupts
// - Send-abort command ends frame with abort
module sft_transmitter
  import sft_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic tx_enable,
  input wire logic cts_active,
  input wire logic crc_reset_cmd,
  input wire logic abort_cmd,
  input wire logic latch_reset_cmd,
  input wire logic pending_reset_cmd,
  input wire logic [3:0] word_length,
  input wire logic byte_valid,
  output logic byte_ready,
  input wire logic [7:0] byte_data,
  output logic serial_out,
  output logic cts_change_irq,
  output logic buffer_empty_irq,
  output logic underrun_end_irq,
  output logic transmit_underrun_end_latch,
  output logic wait_ready_n
);
  sft_state_type state_q;
  logic [15:0] crc_q;
  logic [7:0] shift_q;
  logic [3:0] bits_q;
  logic [3:0] len_q;
  logic [2:0] ones_q;
  logic [4:0] abort_cnt_q;
  logic stuff;
  logic cur_bit;
  logic last_bit;
  logic cts_seen_q;
  logic cts_q;
  logic f_ready;
  logic f_push;
  logic f_valid;
  logic f_pop;
  logic [SFT_FIFO_WIDTH-1:0] f_data;

  // Word length travels with each byte so a change affects later bytes
  // length per character
  sft_fifo #(.WIDTH(SFT_FIFO_WIDTH), .DEPTH(SFT_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(f_push),
    .in_ready(f_ready),
    .in_data({word_length, byte_data}),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  // Bytes offered while ready is low are refused, not silently taken
  assign f_push = byte_valid && byte_ready;
  // Zero insertion after five ones; a run that ends the body is stuffed
  // before the flag, else the far end takes the flag's zero as a stuff bit
  assign stuff = (state_q != SFT_IDLE && state_q != SFT_ABORT) &&
                 (ones_q == 3'h5);
  assign cur_bit = (state_q == SFT_CRC) ? ~crc_q[0] : shift_q[0];
  assign last_bit = !stuff && (bits_q == len_q - 4'h1);
  assign f_pop = f_valid && last_bit &&
                 (state_q == SFT_FLAGS || state_q == SFT_DATA ||
                  state_q == SFT_CLOSE) && !abort_cmd;

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= SFT_IDLE;
      shift_q <= '0;
      bits_q <= '0;
      len_q <= SFT_LEN_RESET;
      abort_cnt_q <= '0;
    end else if (abort_cmd && state_q != SFT_IDLE) begin
      state_q <= SFT_ABORT;
      abort_cnt_q <= '0;
    end else begin
      unique case (state_q)
        SFT_IDLE: begin
          if (tx_enable && cts_active) begin
            state_q <= SFT_FLAGS;
            shift_q <= SFT_FLAG;
            bits_q <= '0;
            len_q <= SFT_LEN_RESET;
          end
        end
        SFT_FLAGS, SFT_DATA, SFT_CLOSE: begin
          if (!stuff) begin
            shift_q <= {1'b0, shift_q[7:1]};
            bits_q <= bits_q + 4'h1;
          end
          if (last_bit) begin
            bits_q <= '0;
            if (f_valid) begin
              state_q <= SFT_DATA;
              shift_q <= f_data[7:0];
              len_q <= (f_data[11:8] < SFT_LEN_MIN ||
                        f_data[11:8] > SFT_LEN_RESET) ?
                       SFT_LEN_RESET : f_data[11:8];
            end else if (state_q == SFT_DATA &&
                         !transmit_underrun_end_latch) begin
              state_q <= SFT_CRC;
              len_q <= SFT_LEN_RESET;
            end else if (!tx_enable) begin
              state_q <= SFT_IDLE;
            end else begin
              // Idle line between frames is filled with flags
              state_q <= (state_q == SFT_DATA) ? SFT_FLAGS : state_q;
              shift_q <= SFT_FLAG;
              len_q <= SFT_LEN_RESET;
            end
          end
        end
        SFT_CRC: begin
          if (!stuff) begin
            bits_q <= bits_q + 4'h1;
            if (bits_q == 4'hf) begin
              state_q <= SFT_CLOSE;
              shift_q <= SFT_FLAG;
              bits_q <= '0;
            end
          end
        end
        SFT_ABORT: begin
          abort_cnt_q <= abort_cnt_q + 5'h01;
          if (abort_cnt_q == SFT_ABORT_ONES - 5'h01) begin
            state_q <= tx_enable ? SFT_FLAGS : SFT_IDLE;
            shift_q <= SFT_FLAG;
            bits_q <= '0;
            len_q <= SFT_LEN_RESET;
          end
        end
        default: state_q <= SFT_IDLE;
      endcase
    end
  end

  // Serial bit and run-of-ones tracking for zero insertion
  always_ff @(posedge clk) begin
    if (reset) begin
      serial_out <= 1'b1;
      ones_q <= '0;
    end else if (state_q == SFT_IDLE || state_q == SFT_ABORT) begin
      serial_out <= 1'b1;
      ones_q <= '0;
    end else if (stuff) begin
      serial_out <= 1'b0;
      ones_q <= '0;
    end else begin
      serial_out <= cur_bit;
      ones_q <= (cur_bit && state_q != SFT_FLAGS && state_q != SFT_CLOSE)
                ? ones_q + 3'h1 : 3'h0;
    end
  end

  // CRC shift-out uses the register as its own shifter
  always_ff @(posedge clk) begin
    if (reset) begin
      crc_q <= SFT_CRC_PRESET;
    end else if (crc_reset_cmd) begin
      crc_q <= SFT_CRC_PRESET;
    end else if (state_q == SFT_CRC && !stuff) begin
      crc_q <= {1'b0, crc_q[15:1]};
    end else if (state_q == SFT_CLOSE && last_bit) begin
      crc_q <= SFT_CRC_PRESET;
    end else if (state_q == SFT_DATA && !stuff) begin
      crc_q <= (crc_q[0] ^ shift_q[0]) ?
               ({1'b0, crc_q[15:1]} ^ SFT_CRC_POLY) : {1'b0, crc_q[15:1]};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      transmit_underrun_end_latch <= 1'b1;
      underrun_end_irq <= 1'b0;
    end else begin
      underrun_end_irq <= 1'b0;
      if (state_q == SFT_DATA && last_bit && !f_valid &&
          !transmit_underrun_end_latch && !abort_cmd) begin
        transmit_underrun_end_latch <= 1'b1;
        underrun_end_irq <= 1'b1;
      end else if (latch_reset_cmd) begin
        transmit_underrun_end_latch <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cts_q <= 1'b0;
      cts_seen_q <= 1'b0;
      cts_change_irq <= 1'b0;
      buffer_empty_irq <= 1'b0;
    end else begin
      cts_q <= cts_active;
      cts_change_irq <= (cts_active != cts_q);
      if (cts_active && !cts_q) begin
        cts_seen_q <= 1'b1;
      end else if (state_q == SFT_IDLE && !tx_enable) begin
        cts_seen_q <= 1'b0;
      end
      if (pending_reset_cmd) begin
        buffer_empty_irq <= 1'b0;
      end
      if (cts_seen_q && f_pop) begin
        buffer_empty_irq <= 1'b1;
      end else if (state_q == SFT_CLOSE && last_bit && !f_valid) begin
        buffer_empty_irq <= 1'b1;
      end
    end
  end

  // Ready only after the CTS interrupt so the first byte follows it.
  // Ready drops for a cycle after each take: the registered flag then
  // never promises room that the last push has already used.
  always_ff @(posedge clk) begin
    if (reset) begin
      byte_ready <= 1'b0;
      wait_ready_n <= 1'b1;
    end else begin
      byte_ready <= f_ready && cts_seen_q && !f_push;
      wait_ready_n <= !(f_ready && cts_seen_q && !f_push);
    end
  end
endmodule // sft_transmitter

/* File: test/sft_transmitter_props.sv */
// Port checker for the SDLC frame transmitter
module sft_transmitter_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic tx_enable,
  input wire logic cts_active,
  input wire logic abort_cmd,
  input wire logic latch_reset_cmd,
  input wire logic pending_reset_cmd,
  input wire logic byte_ready,
  input wire logic serial_out,
  input wire logic cts_change_irq,
  input wire logic buffer_empty_irq,
  input wire logic underrun_end_irq,
  input wire logic transmit_underrun_end_latch,
  input wire logic wait_ready_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_hs; wait_ready_n == !byte_ready; endproperty
  a_hs: assert property (p_hs) else $error("wait line wrong");
  property p_cts; $changed(cts_active) && !$past(reset) |=> cts_change_irq;
  endproperty
  a_cts: assert property (p_cts) else $error("no cts irq");
  property p_flg; $rose(cts_active) && tx_enable |=>
    ##[0:2] !serial_out ##1 serial_out [*6] ##1 !serial_out; endproperty
  a_flg: assert property (p_flg) else $error("no flag");
  property p_und; underrun_end_irq |-> !$past(transmit_underrun_end_latch);
  endproperty
  a_und: assert property (p_und) else $error("latch set");
  // A clear that meets an underrun loses: the set wins
  property p_lat; latch_reset_cmd |=>
    !transmit_underrun_end_latch || underrun_end_irq; endproperty
  a_lat: assert property (p_lat) else $error("latch kept");
  property p_pnd; $fell(buffer_empty_irq) |-> $past(pending_reset_cmd);
  endproperty
  a_pnd: assert property (p_pnd) else $error("irq lost");
  property p_abt; abort_cmd && tx_enable && cts_active |=>
    ##[0:8] serial_out [*8]; endproperty
  a_abt: assert property (p_abt) else $error("no abort");
  property p_end; underrun_end_irq |=>
    ##[14:22] !serial_out ##1 serial_out [*6] ##1 !serial_out; endproperty
  a_end: assert property (p_end) else $error("no close");
endmodule // sft_transmitter_props

bind sft_transmitter sft_transmitter_props sft_transmitter_props_i (
  .clk, .reset, .tx_enable, .cts_active, .abort_cmd, .latch_reset_cmd,
  .pending_reset_cmd, .byte_ready, .serial_out, .cts_change_irq,
  .buffer_empty_irq, .underrun_end_irq, .transmit_underrun_end_latch,
  .wait_ready_n);

/* File: test/sft_host_model.sv */
// Host model that loads queued bytes when the transmitter is ready
module sft_host_model (
  input wire logic clk,
  input wire logic stall,
  input wire logic byte_ready,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic [3:0] word_length
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] q[$];
  logic hold;
  initial begin
    byte_valid = 1'b0;
    {word_length, byte_data} = 12'h800;
  end
  always @(posedge clk) begin
    hold = byte_valid && !byte_ready;
    if (byte_valid && byte_ready) void'(q.pop_front());
    #1;
    byte_valid = q.size() > 0 && (hold || !stall);
    // Idle data toggles so a stale value cannot pass
    if (byte_valid) {word_length, byte_data} = q[0];
    else byte_data = ~byte_data;
  end
endmodule // sft_host_model

/* File: test/sft_transmitter_test.sv */
// Self-checking bench for the SDLC frame transmitter
module sft_transmitter_test;
  timeunit 1ns;
  timeprecision 100ps;
  import sft_pkg::*;
  logic clk, reset, tx_enable, cts_active, crc_reset_cmd, abort_cmd, stall;
  logic latch_reset_cmd, pending_reset_cmd, byte_valid, byte_ready, slow;
  logic serial_out, cts_change_irq, buffer_empty_irq, underrun_end_irq;
  logic transmit_underrun_end_latch, wait_ready_n;
  logic [3:0] word_length;
  logic [7:0] byte_data, w;
  logic [1023:0] frame, expv;
  logic bits[$], rx[$];
  int miscompares, total_checks, ones, nframes, flen, aborts, unders, cyc;
  int n0, a0, u0;
  logic [31:0] r = 32'hd996, sr = 32'hd996;
`define CHK(a, b) begin \
    total_checks++; \
    if ((a) !== (b)) begin \
      miscompares++; \
      $display("[FAIL] %0t got %h exp %h", $time, a, b); \
    end \
  end
  sft_transmitter sft_transmitter_i (.clk, .reset, .tx_enable, .cts_active,
    .crc_reset_cmd, .abort_cmd, .latch_reset_cmd, .pending_reset_cmd,
    .word_length, .byte_valid, .byte_ready, .byte_data, .serial_out,
    .cts_change_irq, .buffer_empty_irq, .underrun_end_irq,
    .transmit_underrun_end_latch, .wait_ready_n);
  sft_host_model sft_host_model_i (.clk, .stall, .byte_ready, .byte_valid,
    .byte_data, .word_length);
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [15:0] fcs();
    logic [15:0] c;
    c = SFT_CRC_PRESET;
    foreach (bits[i]) c = (c >> 1) ^ ((c[0] ^ bits[i]) ? SFT_CRC_POLY : '0);
    return ~c;
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic send(input logic [3:0] l, input logic [7:0] d);
    // data never carries the flag pattern
    if (d == SFT_FLAG) d = ~d;
    sft_host_model_i.q.push_back({l, d});
    for (int i = 0; i < l; i++) bits.push_back(d[i]);
  endtask
  task automatic check_frame();
    logic [15:0] c;
    n0 = nframes;
    for (int i = 0; i < 5000 && nframes == n0; i++) tick(1);
    c = fcs();
    for (int i = 0; i < 16; i++) bits.push_back(c[i]);
    expv = '0;
    foreach (bits[i]) expv[i] = bits[i];
    `CHK(flen, bits.size())
    `CHK(frame, expv)
    bits.delete();
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Line decoder: strips stuffed zeros, cuts frames at flags
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      miscompares++;
      give_verdict();
    end
    if (underrun_end_irq === 1'b1) unders++;
    w = {serial_out, w[7:1]};
    if (ones == 5 && !serial_out) ones = 0;
    else begin
      rx.push_back(serial_out);
      ones = serial_out ? ones + 1 : 0;
    end
    if (ones == 7) aborts++;
    if (ones >= 7) rx.delete();
    if (w === SFT_FLAG && rx.size() > 8) begin
      flen = rx.size() - 8;
      frame = '0;
      for (int i = 0; i < flen; i++) frame[i] = rx[i];
      nframes++;
    end
    if (w === SFT_FLAG) rx.delete();
    #1;
    sr = lfsr(sr);
    stall = sr[0] & slow;
  end
  initial begin
    {reset, tx_enable, cts_active, crc_reset_cmd, abort_cmd} = 5'h10;
    {latch_reset_cmd, pending_reset_cmd, stall, slow} = 4'h0;
    tick(3);
    reset = 1'b0;
    tx_enable = 1'b1;
    tick(2);
    `CHK(byte_ready, 1'b0)
    `CHK(wait_ready_n, 1'b1)
    cts_active = 1'b1;
    tick(1);
    `CHK(cts_change_irq, 1'b1)
    tick(3);
    // CRC mode fixed, then preset, fresh message
    pulse(crc_reset_cmd);
    pulse(latch_reset_cmd);
    `CHK(transmit_underrun_end_latch, 1'b0)
    slow = 1'b1;
    for (int i = 0; i < 64; i++) begin
      r = lfsr(r);
      send(4'h5 + r[1:0], r[15:8]);
    end
    tick(150);
    // A full buffer reopens for one cycle after each pop
    for (int i = 0; i < 8 && byte_ready; i++) tick(1);
    `CHK(byte_ready, 1'b0)
    `CHK(sft_host_model_i.q.size() > 0, 1'b1)
    check_frame();
    tick(2);
    `CHK(buffer_empty_irq, 1'b1)
    `CHK(unders, 1)
    `CHK(transmit_underrun_end_latch, 1'b1)
    $display("test long frame done");
    slow = 1'b0;
    pulse(pending_reset_cmd);
    `CHK(buffer_empty_irq, 1'b0)
    pulse(latch_reset_cmd);
    a0 = aborts;
    n0 = nframes;
    send(4'h8, 8'ha5);
    send(4'h8, 8'h3c);
    tick(14);
    pulse(abort_cmd);
    tick(60);
    bits.delete();
    `CHK(aborts - a0, 1)
    `CHK(nframes, n0)
    $display("test abort done");
    pulse(crc_reset_cmd);
    pulse(latch_reset_cmd);
    u0 = unders;
    send(4'h8, 8'hff);
    send(4'h5, 8'h1f);
    send(4'h7, r[7:0]);
    check_frame();
    `CHK(unders - u0, 1)
    $display("test word length done");
    cts_active = 1'b0;
    tx_enable = 1'b0;
    tick(20);
    `CHK(serial_out, 1'b1)
    $display("test stop done");
    give_verdict();
  end
endmodule // sft_transmitter_test
